//--- logic/rfs_pkg.sv
// Shared constants, status layout and enumerations of the rail fault supervisor
package rfs_pkg;
	// Clock and power-stage flag latency
	localparam int CLK_PERIOD_NS = 50;
	localparam int TAO_LATENCY_NS = 1000;
	// Longest time, rounded down to whole cycles
	localparam int TAO_LATENCY_CYC = TAO_LATENCY_NS / CLK_PERIOD_NS;

	// Phase and current sizing
	localparam int NUM_PHASES = 7;
	localparam int CURRENT_W = 10;
	localparam int PHASE_IDX_W = 8;
	localparam int PAGE_W = 1;
	localparam logic [PHASE_IDX_W-1:0] PHASE_ALL = 8'hff;

	// Reset thresholds
	localparam logic [CURRENT_W-1:0] RAIL_OC_RST = 10'h3ff;
	localparam logic [CURRENT_W-1:0] PHASE_OCL_RST = 10'h082;

	// Fault inputs: temperature, stage, vin over, vin under, iin over; then rail overcurrent
	localparam int NUM_EXT_FAULT = 5;
	localparam int NUM_FAULT = 6;
	localparam int FLT_RAIL_OC = 5;
	// Warning inputs: temperature, vin over, vin under, iin over, pin over
	localparam int NUM_EXT_WARN = 5;
	localparam int WRN_BASE = 6;

	// Status vector positions
	localparam int STAT_CML = 11;
	localparam int STAT_OCL = 12;
	localparam int STAT_NRDY = 13;
	localparam int STAT_STRAP = 14;
	localparam int STAT_W = 15;

	// Reaction code width
	localparam int REACT_W = 2;

	// Selectable fault reaction
	typedef enum logic [1:0] {
		REACT_IGNORE = 2'b00,
		REACT_LATCH = 2'b01,
		REACT_HICCUP = 2'b10,
		REACT_SPARE = 2'b11
	} rfs_react_e;

	// Rail conversion state
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_RUN = 2'b01,
		ST_LATCH = 2'b10,
		ST_HICCUP = 2'b11
	} rfs_state_e;
endpackage

//--- logic/rfs_phase_if.sv
// Signals between the supervisor and one per-phase limiter
`timescale 1ns/1ns
interface rfs_phase_if;
	logic wrEn; // Threshold write strobe
	logic [rfs_pkg::CURRENT_W-1:0] wrData; // New threshold
	logic [rfs_pkg::CURRENT_W-1:0] current; // Phase current sample
	logic over; // Phase above its limit
	modport ctl (output wrEn, output wrData, output current, input over);
	modport phase (input wrEn, input wrData, input current, output over);
endinterface

//--- logic/rfs_phase_limit.sv
// Per-phase cycle-by-cycle current limit threshold and comparator
`timescale 1ns/1ns
module rfs_phase_limit (
	input wire logic clk,
	input wire logic nrst,
	rfs_phase_if.phase port
);
	// Limiter state
	typedef struct packed {
		logic [rfs_pkg::CURRENT_W-1:0] limit;
		logic over;
	} rfs_lim_s;

	rfs_lim_s r;
	rfs_lim_s nx;

	// Threshold load and over-limit compare
	always_comb begin
		nx = r;
		if (port.wrEn) begin
			nx.limit = port.wrData;
		end
		nx.over = port.current > r.limit;
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			r.limit <= rfs_pkg::PHASE_OCL_RST;
		end else begin
			r <= nx;
		end
	end

	assign port.over = r.over;

	// New threshold governs compare from the second cycle on
	a_phase_limit_wr: assert property (@(posedge clk) disable iff (!nrst)
		port.wrEn ##1 !port.wrEn |=> port.over == ($past(port.current) > $past(port.wrData, 2)))
		else $error("phase limit not applied");
endmodule // rfs_phase_limit

//--- logic/rfs_rail_fault_supervisor.sv
// Rail fault supervisor: status, alert, reaction state and current thresholds
//
// Contract
// - Shutdown reaction drops regulator ready
// - Every event sets status, alerts unless masked
// - Enable cycle or clear command clears status
// - Persisting condition re-sets flag after clear
// - Flag pin low tri-states PWM within 1us
// - Not-ready blocks soft-start of idle rail
// - Phase FFh write sets rail overcurrent threshold
// - Other phase write sets that phase limit
// - Phase over limit skips pulses, warns only
`timescale 1ns/1ns
module rfs_rail_fault_supervisor #(
	parameter int NUM_PHASES = rfs_pkg::NUM_PHASES, // Phases on this rail
	parameter int HICCUP_CYCLES = 20000, // Hiccup off time in cycles
	parameter logic [rfs_pkg::PAGE_W-1:0] RAIL_PAGE = 1'h0 // Page served by this rail
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic railEnable,
	input wire logic powerStageFlagPin,
	input wire logic [rfs_pkg::NUM_EXT_FAULT-1:0] faultCond,
	input wire logic [rfs_pkg::NUM_EXT_WARN-1:0] warnCond,
	input wire logic strapInvalid,
	input wire logic cmlError,
	input wire logic [rfs_pkg::NUM_FAULT*rfs_pkg::REACT_W-1:0] faultReaction,
	input wire logic [rfs_pkg::STAT_W-1:0] alertMask,
	input wire logic clearFaults,
	input wire logic ocWrite,
	input wire logic [rfs_pkg::PAGE_W-1:0] ocPage,
	input wire logic [rfs_pkg::PHASE_IDX_W-1:0] ocPhase,
	input wire logic [rfs_pkg::CURRENT_W-1:0] ocValue,
	input wire logic [rfs_pkg::CURRENT_W-1:0] railCurrent,
	input wire logic [NUM_PHASES*rfs_pkg::CURRENT_W-1:0] phaseCurrent,
	output logic regulatorReadyOut,
	output logic regulatorFaultOutN,
	output logic pwmTristate,
	output logic [NUM_PHASES-1:0] pwmSkip,
	output logic softStartGo,
	output logic smbAlertN,
	output logic [rfs_pkg::STAT_W-1:0] statusBits,
	output logic [rfs_pkg::CURRENT_W-1:0] railOcLimit
);
	localparam int HCW = $clog2(HICCUP_CYCLES + 1); // Hiccup counter width
	localparam int TAO_MAX = rfs_pkg::TAO_LATENCY_CYC; // Bound for flag assertion

	// Whole module state
	typedef struct packed {
		logic [1:0] enSync; // Enable synchroniser
		logic [1:0] flagSync; // Flag pin synchroniser
		logic [rfs_pkg::NUM_EXT_FAULT-1:0] flt1; // Fault sync first stage
		logic [rfs_pkg::NUM_EXT_FAULT-1:0] flt2; // Fault sync second stage
		logic [rfs_pkg::NUM_EXT_WARN-1:0] wrn1; // Warning sync first stage
		logic [rfs_pkg::NUM_EXT_WARN-1:0] wrn2; // Warning sync second stage
		logic enPrev; // Enable one cycle ago
		rfs_pkg::rfs_state_e state; // Conversion state
		logic [HCW-1:0] hicCnt; // Hiccup wait counter
		logic [rfs_pkg::STAT_W-1:0] status; // Sticky status bits
		logic [rfs_pkg::CURRENT_W-1:0] railOc; // Rail overcurrent threshold
		logic alertN; // Alert line level
		logic strapBad; // Pinstrap failure, power cycle only
		logic ssGo; // Soft-start start pulse
	} rfs_sup_s;

	rfs_sup_s r;
	rfs_sup_s nx;

	logic [NUM_PHASES-1:0] phaseOver; // Per-phase over-limit flags
	logic enNow; // Synchronised enable
	logic notReady; // Power stage holds flag low
	logic enRise; // Enable turned back on
	logic clr; // Clear request this cycle
	logic [rfs_pkg::NUM_FAULT-1:0] faultNow; // Active fault conditions
	logic [rfs_pkg::STAT_W-1:0] setVec; // Status set terms
	logic tripLatch; // A latch-off fault is active
	logic tripHic; // A hiccup fault is active

	// Per-phase limiters
	rfs_phase_if phIf[NUM_PHASES] ();
	genvar g;
	generate
		for (g = 0; g < NUM_PHASES; g++) begin : gPhase
			assign phIf[g].wrEn = ocWrite && (ocPage == RAIL_PAGE) &&
				(ocPhase == rfs_pkg::PHASE_IDX_W'(g));
			assign phIf[g].wrData = ocValue;
			assign phIf[g].current = phaseCurrent[g*rfs_pkg::CURRENT_W +: rfs_pkg::CURRENT_W];
			assign phaseOver[g] = phIf[g].over;
			rfs_phase_limit uLimit (
				.clk(clk),
				.nrst(nrst),
				.port(phIf[g])
			);
		end
	endgenerate

	// Next-state logic
	always_comb begin
		nx = r;
		// Synchronisers for pins and analog comparators
		nx.enSync = {r.enSync[0], railEnable};
		nx.flagSync = {r.flagSync[0], powerStageFlagPin};
		nx.flt1 = faultCond;
		nx.flt2 = r.flt1;
		nx.wrn1 = warnCond;
		nx.wrn2 = r.wrn1;
		enNow = r.enSync[1];
		notReady = ~r.flagSync[1];
		enRise = enNow & ~r.enPrev;
		nx.enPrev = enNow;
		clr = clearFaults | enRise;
		// Rail overcurrent only during conversion
		faultNow = {(r.state == rfs_pkg::ST_RUN) && (railCurrent > r.railOc), r.flt2};
		// Pinstrap failure held until power cycle
		nx.strapBad = r.strapBad | strapInvalid;
		// Collect status set terms
		setVec = '0;
		setVec[rfs_pkg::NUM_FAULT-1:0] = faultNow;
		setVec[rfs_pkg::WRN_BASE +: rfs_pkg::NUM_EXT_WARN] = r.wrn2;
		setVec[rfs_pkg::STAT_CML] = cmlError;
		setVec[rfs_pkg::STAT_OCL] = |phaseOver;
		setVec[rfs_pkg::STAT_NRDY] = notReady;
		setVec[rfs_pkg::STAT_STRAP] = r.strapBad;
		// Set wins over clear, so a lasting condition re-detects at once
		nx.status = (r.status & ~{rfs_pkg::STAT_W{clr}}) | setVec;
		nx.alertN = ~|(nx.status & ~alertMask);
		// Reactions of active faults
		tripLatch = r.strapBad;
		tripHic = 1'b0;
		for (int i = 0; i < rfs_pkg::NUM_FAULT; i++) begin
			if (faultNow[i]) begin
				case (rfs_pkg::rfs_react_e'(faultReaction[i*rfs_pkg::REACT_W +: rfs_pkg::REACT_W]))
					rfs_pkg::REACT_IGNORE: begin
					end
					rfs_pkg::REACT_HICCUP: begin
						tripHic = 1'b1;
					end
					default: begin
						tripLatch = 1'b1;
					end
				endcase
			end
		end
		// Rail conversion state machine
		nx.ssGo = 1'b0;
		case (r.state)
			rfs_pkg::ST_OFF: begin
				if (tripLatch) begin
					nx.state = rfs_pkg::ST_LATCH;
				end else if (enNow && !notReady && !tripHic) begin
					nx.state = rfs_pkg::ST_RUN;
					nx.ssGo = 1'b1;
				end
			end
			rfs_pkg::ST_RUN: begin
				if (tripLatch) begin
					nx.state = rfs_pkg::ST_LATCH;
				end else if (tripHic) begin
					nx.state = rfs_pkg::ST_HICCUP;
					nx.hicCnt = HCW'(HICCUP_CYCLES - 1);
				end else if (!enNow) begin
					nx.state = rfs_pkg::ST_OFF;
				end
			end
			rfs_pkg::ST_LATCH: begin
				// Leave only on clear with the cause gone
				if (clr && !tripLatch) begin
					nx.state = rfs_pkg::ST_OFF;
				end
			end
			rfs_pkg::ST_HICCUP: begin
				if (tripLatch) begin
					nx.state = rfs_pkg::ST_LATCH;
				end else if (!enNow || r.hicCnt == '0) begin
					nx.state = rfs_pkg::ST_OFF;
				end else begin
					nx.hicCnt = r.hicCnt - 1'b1;
				end
			end
			default: begin
				nx.state = rfs_pkg::ST_LATCH;
			end
		endcase
		// Rail threshold write at the whole-rail phase index
		if (ocWrite && (ocPage == RAIL_PAGE) && (ocPhase == rfs_pkg::PHASE_ALL)) begin
			nx.railOc = ocValue;
		end
	end

	// State register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
			// Flag pin idles high, so no false not-ready after reset
			r.flagSync <= '1;
			r.railOc <= rfs_pkg::RAIL_OC_RST;
			r.alertN <= 1'b1;
		end else begin
			r <= nx;
		end
	end

	// Outputs from state
	assign regulatorReadyOut = (r.state == rfs_pkg::ST_RUN) && !notReady;
	assign regulatorFaultOutN = !((r.state == rfs_pkg::ST_LATCH) ||
		(r.state == rfs_pkg::ST_HICCUP));
	assign pwmTristate = (r.state != rfs_pkg::ST_RUN) || notReady;
	assign pwmSkip = phaseOver & {NUM_PHASES{r.state == rfs_pkg::ST_RUN}};
	assign softStartGo = r.ssGo;
	assign smbAlertN = r.alertN;
	assign statusBits = r.status;
	assign railOcLimit = r.railOc;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_ready_on_shutdown: assert property ((r.state == rfs_pkg::ST_LATCH) |-> !regulatorReadyOut)
		else $error("ready high while latched off");
	a_fault_sets_status: assert property (faultCond[0] [*3] |=> statusBits[0])
		else $error("fault did not set status");
	a_alert_unmasked: assert property (smbAlertN == !(|(statusBits & ~$past(alertMask))))
		else $error("unmasked status did not alert");
	a_clear_cml_bit: assert property (clearFaults && !cmlError |=> !statusBits[rfs_pkg::STAT_CML])
		else $error("clear left comm error set");
	a_clear_redetect: assert property (clearFaults && r.flt2[0] |=> statusBits[0])
		else $error("present fault lost on clear");
	a_flag_tristate: assert property ($fell(powerStageFlagPin) ##1 !powerStageFlagPin
		|-> ##[1:TAO_MAX] pwmTristate)
		else $error("flag low did not tri-state");
	a_notready_blocks: assert property ((r.state == rfs_pkg::ST_OFF) && notReady
		|=> (r.state != rfs_pkg::ST_RUN) && !softStartGo)
		else $error("soft-start while not ready");
	a_rail_oc_write: assert property (ocWrite && (ocPage == RAIL_PAGE) && (ocPhase == rfs_pkg::PHASE_ALL)
		|=> railOcLimit == $past(ocValue))
		else $error("rail threshold not written");
	a_phase_keeps_rail: assert property (ocWrite && (ocPhase != rfs_pkg::PHASE_ALL)
		|=> $stable(railOcLimit))
		else $error("phase write altered rail threshold");
	a_skip_warn_only: assert property ((|pwmSkip) |=> statusBits[rfs_pkg::STAT_OCL])
		else $error("pulse skip without warning");
	a_latch_holds: assert property ((r.state == rfs_pkg::ST_LATCH) && !clearFaults && !enRise
		|=> (r.state == rfs_pkg::ST_LATCH) && pwmTristate)
		else $error("latch-off released without clear");
	a_hiccup_retry: assert property ((r.state == rfs_pkg::ST_HICCUP) && (r.hicCnt == '0) && !tripLatch
		|=> (r.state == rfs_pkg::ST_OFF))
		else $error("hiccup did not retry");

	c_soft_start: cover property (softStartGo);
	c_latch_clear: cover property ((r.state == rfs_pkg::ST_LATCH) ##1 (r.state == rfs_pkg::ST_OFF));
	c_hiccup_entry: cover property ((r.state == rfs_pkg::ST_RUN) ##1 (r.state == rfs_pkg::ST_HICCUP));
	c_pulse_skip: cover property (|pwmSkip);
endmodule // rfs_rail_fault_supervisor

//--- sim/rfs_stage_model.sv
// Power stage model: shared ready flag and phase currents
`timescale 1ns/1ns
module rfs_stage_model #(
	parameter int NP = rfs_pkg::NUM_PHASES // Phases on the rail
) (
	input wire logic clk,
	input wire logic stageNotReady,
	input wire logic [NP*rfs_pkg::CURRENT_W-1:0] load,
	input wire logic pwmTristate,
	output logic powerStageFlagPin,
	output logic [NP*rfs_pkg::CURRENT_W-1:0] phaseCurrent
);
	// Open-drain flag, pull-up wins when released
	initial powerStageFlagPin = 1'b1;
	// Stage pulls the flag low while it is not ready
	always @(posedge clk) begin
		powerStageFlagPin <= !stageNotReady;
	end
	// No switching, no current while PWM is tri-stated
	assign phaseCurrent = pwmTristate ? '0 : load;
endmodule // rfs_stage_model

//--- sim/tb_top.sv
// Self-checking bench of the rail fault supervisor
`timescale 1ns/1ns
`define CHK_EQ(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
`define WAITC(c, n) begin for (int k = 0; k < (n) && (c) !== 1'b1; k++) @(negedge clk); `CHK_EQ(c, 1'b1) end
module tb_top;
	localparam int NP = rfs_pkg::NUM_PHASES; // Phases on the rail
	localparam int CW = rfs_pkg::CURRENT_W; // Current width
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic railEnable = 1'b0;
	logic powerStageFlagPin;
	logic [rfs_pkg::NUM_EXT_FAULT-1:0] faultCond = '0;
	logic [rfs_pkg::NUM_EXT_WARN-1:0] warnCond = '0;
	logic strapInvalid = 1'b0;
	logic cmlError = 1'b0;
	logic [rfs_pkg::NUM_FAULT*rfs_pkg::REACT_W-1:0] faultReaction = '0;
	logic [rfs_pkg::STAT_W-1:0] alertMask = '0;
	logic clearFaults = 1'b0;
	logic ocWrite = 1'b0;
	logic [rfs_pkg::PAGE_W-1:0] ocPage = '0;
	logic [rfs_pkg::PHASE_IDX_W-1:0] ocPhase = '0;
	logic [CW-1:0] ocValue = '0;
	logic [CW-1:0] railCurrent = '0;
	logic [NP*CW-1:0] phaseCurrent;
	logic [NP*CW-1:0] load = {NP{10'h010}}; // Nominal phase load
	logic stageNotReady = 1'b0;
	logic regulatorReadyOut, regulatorFaultOutN, pwmTristate, softStartGo, smbAlertN;
	logic [NP-1:0] pwmSkip;
	logic [rfs_pkg::STAT_W-1:0] statusBits;
	logic [CW-1:0] railOcLimit;
	int err_count = 0;
	int num_checks = 0;
	int starts = 0; // Soft-start pulses seen
	int s0;
	// 20 MHz clock
	always #25 clk = ~clk;
	// Count soft-start pulses
	always @(posedge clk) begin
		if (softStartGo === 1'b1) starts <= starts + 1;
	end
	rfs_rail_fault_supervisor #(.HICCUP_CYCLES(8)) rfs_rail_fault_supervisor_i (.clk(clk),
		.nrst(nrst), .railEnable(railEnable), .powerStageFlagPin(powerStageFlagPin),
		.faultCond(faultCond), .warnCond(warnCond), .strapInvalid(strapInvalid),
		.cmlError(cmlError), .faultReaction(faultReaction), .alertMask(alertMask),
		.clearFaults(clearFaults), .ocWrite(ocWrite), .ocPage(ocPage), .ocPhase(ocPhase),
		.ocValue(ocValue), .railCurrent(railCurrent), .phaseCurrent(phaseCurrent),
		.regulatorReadyOut(regulatorReadyOut), .regulatorFaultOutN(regulatorFaultOutN),
		.pwmTristate(pwmTristate), .pwmSkip(pwmSkip), .softStartGo(softStartGo),
		.smbAlertN(smbAlertN), .statusBits(statusBits), .railOcLimit(railOcLimit));
	rfs_stage_model #(.NP(NP)) rfs_stage_model_i (.clk(clk), .stageNotReady(stageNotReady),
		.load(load), .pwmTristate(pwmTristate), .powerStageFlagPin(powerStageFlagPin),
		.phaseCurrent(phaseCurrent));
	// Wait n settled points
	task automatic nc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Clear command after the causes have had time to settle
	task automatic clr(input int settle);
		nc(settle);
		@(posedge clk);
		clearFaults <= 1'b1;
		@(posedge clk);
		clearFaults <= 1'b0;
		nc(2);
	endtask
	// Threshold write strobe
	task automatic ocw(input logic [0:0] pg, input logic [7:0] ph, input logic [9:0] v);
		@(posedge clk);
		ocWrite <= 1'b1;
		ocPage <= pg;
		ocPhase <= ph;
		ocValue <= v;
		@(posedge clk);
		ocWrite <= 1'b0;
		nc(1);
	endtask
	// Verdict and end of run
	task automatic test_done();
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		test_done();
	end
	// Main sequence
	initial begin
		nc(15);
		`CHK_EQ(statusBits, 15'h0000)
		`CHK_EQ(railOcLimit, rfs_pkg::RAIL_OC_RST)
		`CHK_EQ(pwmTristate, 1'b1)
		@(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		railEnable <= 1'b1;
		`WAITC(softStartGo, 10)
		nc(1);
		`CHK_EQ(regulatorReadyOut, 1'b1)
		// Whole-rail threshold, wrong page refused
		ocw(1'h0, 8'hff, 10'h100);
		`CHK_EQ(railOcLimit, 10'h100)
		ocw(1'h1, 8'hff, 10'h200);
		`CHK_EQ(railOcLimit, 10'h100)
		// Phase 2 lowered, phase 3 write on other page refused
		ocw(1'h0, 8'h02, 10'h050);
		ocw(1'h1, 8'h03, 10'h001);
		@(posedge clk);
		load[2*CW +: CW] <= 10'h060;
		load[3*CW +: CW] <= 10'h060;
		nc(4);
		`CHK_EQ(pwmSkip, 7'h04)
		`CHK_EQ(statusBits[rfs_pkg::STAT_OCL], 1'b1)
		`CHK_EQ(regulatorReadyOut, 1'b1)
		@(posedge clk);
		load <= {NP{10'h010}};
		clr(4);
		`CHK_EQ(statusBits, 15'h0000)
		// Each warning, odd ones masked from the alert
		for (int i = 0; i < rfs_pkg::NUM_EXT_WARN; i++) begin
			@(posedge clk);
			alertMask <= 15'(i % 2) << (rfs_pkg::WRN_BASE + i);
			warnCond <= 5'(1) << i;
			nc(4);
			`CHK_EQ(statusBits, 15'(1) << (rfs_pkg::WRN_BASE + i))
			`CHK_EQ(smbAlertN, 1'(i % 2))
			@(posedge clk);
			warnCond <= '0;
			clr(4);
			`CHK_EQ(statusBits, 15'h0000)
			`CHK_EQ(smbAlertN, 1'b1)
		end
		@(posedge clk);
		alertMask <= '0;
		cmlError <= 1'b1;
		@(posedge clk);
		cmlError <= 1'b0;
		warnCond <= 5'h01;
		nc(4);
		`CHK_EQ(statusBits[rfs_pkg::STAT_CML], 1'b1)
		// Clear while the warning persists
		clr(0);
		`CHK_EQ(statusBits, 15'(1) << rfs_pkg::WRN_BASE)
		@(posedge clk);
		warnCond <= '0;
		clr(4);
		`CHK_EQ(statusBits, 15'h0000)
		// Ignore, latch-off, hiccup on over-temperature
		for (int r = 0; r < 3; r++) begin
			s0 = starts;
			@(posedge clk);
			faultReaction <= 12'(r);
			faultCond <= 5'h01;
			nc(6);
			`CHK_EQ(statusBits[0], 1'b1)
			`CHK_EQ(regulatorReadyOut, 1'(r == 0))
			`CHK_EQ(regulatorFaultOutN, 1'(r == 0))
			`CHK_EQ(pwmTristate, 1'(r != 0))
			@(posedge clk);
			faultCond <= '0;
			nc(20);
			if (r == 1) begin
				`CHK_EQ(pwmTristate, 1'b1)
				@(posedge clk);
				railEnable <= 1'b0;
				nc(4);
				@(posedge clk);
				railEnable <= 1'b1;
			end else begin
				clr(0);
			end
			nc(12);
			`CHK_EQ(starts, s0 + int'(r != 0))
			`CHK_EQ(statusBits, 15'h0000)
			`CHK_EQ(regulatorReadyOut, 1'b1)
		end
		// Rail overcurrent against the programmed threshold
		@(posedge clk);
		faultReaction <= 12'h400;
		railCurrent <= 10'h101;
		nc(4);
		`CHK_EQ(statusBits[rfs_pkg::FLT_RAIL_OC], 1'b1)
		`CHK_EQ(regulatorFaultOutN, 1'b0)
		@(posedge clk);
		railCurrent <= 10'h100;
		clr(1);
		`WAITC(softStartGo, 10)
		// Stage not ready: tri-state and no soft-start
		@(posedge clk);
		stageNotReady <= 1'b1;
		`WAITC(pwmTristate, rfs_pkg::TAO_LATENCY_CYC + 1)
		`CHK_EQ(regulatorReadyOut, 1'b0)
		nc(1);
		`CHK_EQ(statusBits[rfs_pkg::STAT_NRDY], 1'b1)
		s0 = starts;
		@(posedge clk);
		railEnable <= 1'b0;
		nc(4);
		@(posedge clk);
		railEnable <= 1'b1;
		nc(10);
		`CHK_EQ(starts, s0)
		@(posedge clk);
		stageNotReady <= 1'b0;
		`WAITC(softStartGo, 10)
		clr(4);
		`CHK_EQ(statusBits, 15'h0000)
		// Strap failure latches off; clear cannot release it
		@(posedge clk);
		strapInvalid <= 1'b1;
		@(posedge clk);
		strapInvalid <= 1'b0;
		clr(2);
		`CHK_EQ(statusBits[rfs_pkg::STAT_STRAP], 1'b1)
		`CHK_EQ(regulatorReadyOut, 1'b0)
		`CHK_EQ(regulatorFaultOutN, 1'b0)
		// Reset in mid-run releases it, rail starts again
		@(posedge clk);
		nrst <= 1'b0;
		nc(2);
		`CHK_EQ(statusBits, 15'h0000)
		`CHK_EQ(railOcLimit, rfs_pkg::RAIL_OC_RST)
		@(posedge clk);
		nrst <= 1'b1;
		`WAITC(softStartGo, 10)
		nc(1);
		`CHK_EQ(regulatorReadyOut, 1'b1)
		test_done();
	end
endmodule // tb_top
